// [core/phc_pkg.sv]
// Purpose: shared constants and types for the peak hold comparator
// Assumes: signed two's complement position counts
// Notes: none
`default_nettype none
package phc_pkg;
    localparam int PHC_W = 32;
    localparam int PHC_NSET = 4;
    localparam int PHC_SEL_W = 2;
    localparam logic [PHC_W-1:0] PHC_ZERO = 32'h00000000;
    typedef enum logic [1:0] {
        PHC_MODE_CUR,
        PHC_MODE_MAX,
        PHC_MODE_MIN,
        PHC_MODE_PP
    } phc_mode_t;
    typedef enum logic [1:0] {
        PHC_JUDGE_GO,
        PHC_JUDGE_UPPER_NG,
        PHC_JUDGE_LOWER_NG
    } phc_judge_t;
    typedef enum {
        PHC_ST_WAIT_REF,
        PHC_ST_MEASURE
    } phc_state_t;
endpackage : phc_pkg
`default_nettype wire

// [core/phc_sync.sv]
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: single clock domain on the output side
// Notes: first stage feeds only the second stage
`default_nettype none
module phc_sync (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_d,
    output logic o_q
);
    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;

    always_comb begin
        meta_nxt = i_d;
        q_nxt = meta_r;
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= 1'b0;
            q_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign o_q = q_r;
endmodule : phc_sync
`default_nettype wire

// [core/phc_judge.sv]
// Purpose: go/no-go comparator against one limit pair
// Assumes: signed values, limits inclusive
// Notes: purely combinational; caller registers the result
`default_nettype none
module phc_judge
    import phc_pkg::*;
(
    input wire logic signed [PHC_W-1:0] i_value,
    input wire logic signed [PHC_W-1:0] i_upper,
    input wire logic signed [PHC_W-1:0] i_lower,
    output phc_judge_t o_judge
);
    always_comb begin
        if (i_value > i_upper) begin
            o_judge = PHC_JUDGE_UPPER_NG;
        end else if (i_value < i_lower) begin
            o_judge = PHC_JUDGE_LOWER_NG;
        end else begin
            o_judge = PHC_JUDGE_GO;
        end
    end
endmodule : phc_judge
`default_nettype wire

// [core/phc_peak_hold_comparator.sv]
// Purpose: current/max/min/peak-to-peak tracking with go/no-go judgment
// Assumes: position count and commands come from logic on i_ref_clk
// Notes: reset, start and reference pulses are pins and are synchronised
`default_nettype none
module phc_peak_hold_comparator
    import phc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic signed [PHC_W-1:0] i_count,
    input wire logic i_ref_use,
    input wire logic i_ref_pin,
    input wire logic i_reset_pin,
    input wire logic i_start_pin,
    input wire logic i_start_is_hold,
    input wire logic i_preset_pulse,
    input wire logic signed [PHC_W-1:0] i_preset_value,
    input wire logic i_offset_clear,
    input wire logic i_pause,
    input wire logic [1:0] i_mode,
    input wire logic [PHC_SEL_W-1:0] i_limit_sel,
    input wire logic i_limit_wr,
    input wire logic [PHC_SEL_W-1:0] i_limit_wr_idx,
    input wire logic signed [PHC_W-1:0] i_limit_upper,
    input wire logic signed [PHC_W-1:0] i_limit_lower,
    output logic o_measuring,
    output logic o_offset_valid,
    output logic signed [PHC_W-1:0] o_current,
    output logic signed [PHC_W-1:0] o_max,
    output logic signed [PHC_W-1:0] o_min,
    output logic signed [PHC_W-1:0] o_pp,
    output logic signed [PHC_W-1:0] o_value,
    output logic [1:0] o_judge,
    output logic o_hold_active
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detect
    logic ref_s;
    logic reset_s;
    logic start_s;
    logic ref_d_r;
    logic reset_d_r;
    logic start_d_r;
    logic ref_rise;
    logic reset_rise;
    logic start_rise;

    phc_sync u_sync_ref (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_d(i_ref_pin),
        .o_q(ref_s)
    );
    phc_sync u_sync_reset (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_d(i_reset_pin),
        .o_q(reset_s)
    );
    phc_sync u_sync_start (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_d(i_start_pin),
        .o_q(start_s)
    );

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ref_d_r <= 1'b0;
            reset_d_r <= 1'b0;
            start_d_r <= 1'b0;
        end else begin
            ref_d_r <= ref_s;
            reset_d_r <= reset_s;
            start_d_r <= start_s;
        end
    end

    assign ref_rise = ref_s & ~ref_d_r;
    assign reset_rise = reset_s & ~reset_d_r;
    assign start_rise = start_s & ~start_d_r;

    ////////////////////////////////////////////////////////////////////
    // limit pair store
    logic signed [PHC_W-1:0] upper_r [PHC_NSET];
    logic signed [PHC_W-1:0] lower_r [PHC_NSET];

    genvar g;
    generate
        for (g = 0; g < PHC_NSET; g++) begin : g_lim
            logic signed [PHC_W-1:0] up_nxt;
            logic signed [PHC_W-1:0] lo_nxt;
            always_comb begin
                up_nxt = upper_r[g];
                lo_nxt = lower_r[g];
                if (i_limit_wr && (i_limit_wr_idx == PHC_SEL_W'(g))) begin
                    up_nxt = i_limit_upper;
                    lo_nxt = i_limit_lower;
                end
            end
            always_ff @(posedge i_ref_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    upper_r[g] <= PHC_ZERO;
                    lower_r[g] <= PHC_ZERO;
                end else begin
                    upper_r[g] <= up_nxt;
                    lower_r[g] <= lo_nxt;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // measurement state
    phc_state_t state_r;
    phc_state_t state_nxt;
    logic offset_valid_r;
    logic offset_valid_nxt;
    logic setup_r;
    logic setup_nxt;
    logic signed [PHC_W-1:0] offset_r;
    logic signed [PHC_W-1:0] offset_nxt;
    logic signed [PHC_W-1:0] base_r;
    logic signed [PHC_W-1:0] base_nxt;
    logic signed [PHC_W-1:0] cur_r;
    logic signed [PHC_W-1:0] cur_nxt;
    logic signed [PHC_W-1:0] max_r;
    logic signed [PHC_W-1:0] max_nxt;
    logic signed [PHC_W-1:0] min_r;
    logic signed [PHC_W-1:0] min_nxt;
    logic tracking_r;
    logic tracking_nxt;
    logic signed [PHC_W-1:0] raw_cur;

    // current value is count relative to a base; base shifts on reset/preset/reference
    assign raw_cur = i_count - base_r;

    always_comb begin
        state_nxt = state_r;
        offset_valid_nxt = offset_valid_r;
        setup_nxt = setup_r;
        offset_nxt = offset_r;
        base_nxt = base_r;
        tracking_nxt = tracking_r;
        cur_nxt = (state_r == PHC_ST_MEASURE) ? raw_cur : PHC_ZERO;
        max_nxt = max_r;
        min_nxt = min_r;
        if (tracking_r && !i_pause && state_r == PHC_ST_MEASURE) begin
            if (cur_nxt > max_r) begin
                max_nxt = cur_nxt;
            end
            if (cur_nxt < min_r) begin
                min_nxt = cur_nxt;
            end
        end
        if (i_offset_clear) begin
            offset_valid_nxt = 1'b0;
        end
        if (reset_rise) begin
            base_nxt = i_count;
            cur_nxt = PHC_ZERO;
            max_nxt = PHC_ZERO;
            min_nxt = PHC_ZERO;
            tracking_nxt = 1'b0;
            setup_nxt = 1'b0;
            if (i_ref_use) begin
                state_nxt = PHC_ST_WAIT_REF;
            end
        end else if (state_r == PHC_ST_WAIT_REF) begin
            if (!i_ref_use) begin
                state_nxt = PHC_ST_MEASURE;
            end else if (ref_rise) begin
                state_nxt = PHC_ST_MEASURE;
                if (offset_valid_r) begin
                    base_nxt = i_count - offset_r;
                    cur_nxt = offset_r;
                end else begin
                    base_nxt = i_count;
                    setup_nxt = 1'b1;
                end
            end
        end else begin
            if (i_preset_pulse) begin
                base_nxt = i_count - i_preset_value;
                cur_nxt = i_preset_value;
                if (i_ref_use && setup_r) begin
                    // offset is the preset expressed at the reference position
                    offset_nxt = i_preset_value - raw_cur;
                    offset_valid_nxt = 1'b1;
                    setup_nxt = 1'b0;
                end
            end
            if (start_rise && !i_start_is_hold) begin
                tracking_nxt = 1'b1;
                max_nxt = cur_nxt;
                min_nxt = cur_nxt;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= PHC_ST_WAIT_REF;
            offset_valid_r <= 1'b0;
            setup_r <= 1'b0;
            offset_r <= PHC_ZERO;
            base_r <= PHC_ZERO;
            cur_r <= PHC_ZERO;
            max_r <= PHC_ZERO;
            min_r <= PHC_ZERO;
            tracking_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            offset_valid_r <= offset_valid_nxt;
            setup_r <= setup_nxt;
            offset_r <= offset_nxt;
            base_r <= base_nxt;
            cur_r <= cur_nxt;
            max_r <= max_nxt;
            min_r <= min_nxt;
            tracking_r <= tracking_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reported value and judgment
    phc_mode_t mode;
    logic signed [PHC_W-1:0] pp;
    logic signed [PHC_W-1:0] sel_val;
    logic signed [PHC_W-1:0] value_r;
    logic signed [PHC_W-1:0] value_nxt;
    phc_judge_t judge;
    phc_judge_t judge_r;
    phc_judge_t judge_nxt;
    logic freeze;
    logic is_peak;

    assign mode = phc_mode_t'(i_mode);
    assign pp = max_r - min_r;
    assign is_peak = (mode != PHC_MODE_CUR);

    always_comb begin
        unique case (mode)
            PHC_MODE_CUR: sel_val = cur_r;
            PHC_MODE_MAX: sel_val = max_r;
            PHC_MODE_MIN: sel_val = min_r;
            PHC_MODE_PP: sel_val = pp;
        endcase
    end

    phc_judge u_judge (
        .i_value(sel_val),
        .i_upper(upper_r[i_limit_sel]),
        .i_lower(lower_r[i_limit_sel]),
        .o_judge(judge)
    );

    // latch acts on the held level; peak modes ignore it
    assign freeze = (i_start_is_hold && start_s && !is_peak)
        || (i_pause && is_peak);

    always_comb begin
        value_nxt = value_r;
        judge_nxt = judge_r;
        if (!freeze) begin
            value_nxt = sel_val;
            judge_nxt = judge;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            value_r <= PHC_ZERO;
            judge_r <= PHC_JUDGE_GO;
        end else begin
            value_r <= value_nxt;
            judge_r <= judge_nxt;
        end
    end

    assign o_measuring = (state_r == PHC_ST_MEASURE);
    assign o_offset_valid = offset_valid_r;
    assign o_current = cur_r;
    assign o_max = max_r;
    assign o_min = min_r;
    assign o_pp = pp;
    assign o_value = value_r;
    assign o_judge = judge_r;
    assign o_hold_active = freeze;
endmodule : phc_peak_hold_comparator
`default_nettype wire

// [verif/phc_host_model.sv]
// Purpose: host model sending open, preset and commit to the block
// Assumes: one command sequence per go pulse
// Notes: i_gap stretches the spacing between the three steps
`default_nettype none
module phc_host_model
    import phc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_go,
    input wire logic [3:0] i_gap,
    input wire logic signed [PHC_W-1:0] i_value,
    output logic o_preset_pulse,
    output logic signed [PHC_W-1:0] o_preset_value,
    output logic o_done
);
    timeunit 1ns;
    timeprecision 100ps;
    int phase = 0;
    int wait_c = 0;
    initial begin
        o_preset_pulse = 1'h0;
        o_preset_value = '0;
        o_done = 1'h0;
    end
    ////////////////////////////////////////
    always @(posedge i_ref_clk) begin
        o_preset_pulse <= 1'h0;
        o_done <= 1'h0;
        // released value toggles so a stale value is never taken for real
        o_preset_value <= ~o_preset_value;
        if (wait_c > 0) begin
            wait_c <= wait_c - 1;
        end else if (phase == 0 && i_go) begin
            phase <= 1; // open first
            wait_c <= i_gap;
        end else if (phase == 1) begin
            o_preset_pulse <= 1'h1; // preset second
            o_preset_value <= i_value;
            phase <= 2;
            wait_c <= i_gap;
        end else if (phase == 2) begin
            o_done <= 1'h1; // commit last
            phase <= 0;
        end
    end
endmodule : phc_host_model
`default_nettype wire

// [verif/phc_checker_sva.sv]
// Purpose: port checks for the peak hold comparator
// Assumes: single clock, pins act a few edges after they rise
// Notes: edges near a reset or reference pin event are judged only by pp_diff_a
`default_nettype none
module phc_checker_sva
    import phc_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic signed [PHC_W-1:0] i_count,
    input wire logic i_ref_use,
    input wire logic i_ref_pin,
    input wire logic i_reset_pin,
    input wire logic i_start_pin,
    input wire logic i_preset_pulse,
    input wire logic signed [PHC_W-1:0] i_preset_value,
    input wire logic i_pause,
    input wire logic [1:0] i_mode,
    input wire logic o_measuring,
    input wire logic o_offset_valid,
    input wire logic signed [PHC_W-1:0] o_current,
    input wire logic signed [PHC_W-1:0] o_max,
    input wire logic signed [PHC_W-1:0] o_min,
    input wire logic signed [PHC_W-1:0] o_pp,
    input wire logic signed [PHC_W-1:0] o_value,
    input wire logic [1:0] o_judge,
    input wire logic o_hold_active
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);
    logic [4:0] hist_r;
    logic [4:0] hist_nxt;
    logic quiet;
    always_comb begin
        hist_nxt = {hist_r[3:0], i_reset_pin | i_ref_pin};
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            hist_r <= 5'h1F;
        end else begin
            hist_r <= hist_nxt;
        end
    end
    assign quiet = (hist_r == 5'h00);
    ////////////////////////////////////////
    pp_diff_a: assert property ((o_pp == o_max - o_min) && (o_max >= o_min))
        else $error("pp is not max minus min");
    cur_report_a: assert property (
        (quiet && i_mode == 2'h0 && $past(i_mode) == 2'h0 && !$past(o_hold_active))
        |-> o_value == $past(o_current)) else $error("value is not current");
    max_report_a: assert property (
        (quiet && i_mode == 2'h1 && $past(i_mode) == 2'h1 && !$past(o_hold_active))
        |-> o_value == $past(o_max)) else $error("value is not max");
    hold_freeze_a: assert property (
        (quiet && $past(o_hold_active)) |-> $stable(o_value) && $stable(o_judge))
        else $error("output moved while frozen");
    pause_peak_a: assert property (
        (i_pause && quiet && !(|{i_start_pin, $past(i_start_pin), $past(i_start_pin, 2)}))
        |=> $stable(o_max) && $stable(o_min)) else $error("peaks moved in pause");
    cur_track_a: assert property (
        (quiet && o_measuring && $past(o_measuring) && !i_preset_pulse)
        |=> o_current - $past(o_current) == $past(i_count) - $past(i_count, 2))
        else $error("current does not follow count");
    preset_load_a: assert property (
        (quiet && i_preset_pulse && !i_ref_use && o_measuring)
        |=> o_current == $past(i_preset_value)) else $error("preset not loaded");
    ref_wait_a: assert property (
        (quiet && i_ref_use && !o_measuring) |=> !o_measuring)
        else $error("measuring without reference");
    upper_ng_c: cover property (o_judge == 2'h1);
    hold_seen_c: cover property ($rose(o_hold_active));
    offset_set_c: cover property ($rose(o_offset_valid));
endmodule : phc_checker_sva
`default_nettype wire

// [verif/test_peak_hold_comparator.sv]
// Purpose: self-checking bench for the peak hold comparator
// Assumes: 40 MHz clock, inputs driven 2 ns after the rising edge
// Notes: table rows cover tracking and judgment, the rest by hand
`default_nettype none
module test_peak_hold_comparator import phc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic signed [PHC_W-1:0] cnt;
        phc_mode_t md;
        logic [1:0] sel;
        logic signed [PHC_W-1:0] val;
        phc_judge_t jd;
    } phc_row_t;
    phc_row_t rows [7] = '{
        '{32'h6E, PHC_MODE_CUR, 2'h0, 32'h3C, PHC_JUDGE_GO},
        '{32'h6F, PHC_MODE_CUR, 2'h0, 32'h3D, PHC_JUDGE_UPPER_NG},
        '{32'h5A, PHC_MODE_MIN, 2'h0, 32'h28, PHC_JUDGE_GO},
        '{32'h59, PHC_MODE_MIN, 2'h0, 32'h27, PHC_JUDGE_LOWER_NG},
        '{32'h5F, PHC_MODE_MAX, 2'h1, 32'h3D, PHC_JUDGE_GO},
        '{32'h5F, PHC_MODE_PP, 2'h2, 32'h16, PHC_JUDGE_UPPER_NG},
        '{32'h5F, PHC_MODE_PP, 2'h3, 32'h16, PHC_JUDGE_LOWER_NG}};
    logic signed [PHC_W-1:0] lim_u [4] = '{32'h3C, 32'h46, 32'h0, 32'h64};
    logic signed [PHC_W-1:0] lim_l [4] = '{32'h28, 32'h37, 32'hFFFFFFF6, 32'h5A};
    logic i_ref_clk = 1'h0, i_nrst = 1'h0, i_ref_use = 1'h0, i_ref_pin = 1'h0;
    logic i_reset_pin = 1'h0, i_start_pin = 1'h0, i_start_is_hold = 1'h0, go = 1'h0;
    logic i_offset_clear = 1'h0, i_pause = 1'h0, i_limit_wr = 1'h0;
    logic [1:0] i_mode = 2'h0, i_limit_sel = 2'h0, i_limit_wr_idx = 2'h0;
    logic [3:0] host_gap = 4'h0;
    logic signed [PHC_W-1:0] i_count = 32'h0, i_limit_upper = 32'h0, i_limit_lower = 32'h0;
    logic signed [PHC_W-1:0] host_val = 32'h0, ecur, emax, emin;
    logic i_preset_pulse, host_done, o_measuring, o_offset_valid, o_hold_active;
    logic signed [PHC_W-1:0] i_preset_value, o_current, o_max, o_min, o_pp, o_value;
    logic [1:0] o_judge;
    int fails = 0, check_count = 0, cyc = 0;
    phc_peak_hold_comparator DUT (.*);
    phc_host_model host (.i_ref_clk, .i_go(go), .i_gap(host_gap), .i_value(host_val),
        .o_preset_pulse(i_preset_pulse), .o_preset_value(i_preset_value), .o_done(host_done));
    always #12.5 i_ref_clk = ~i_ref_clk;
    ////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #2;
    endtask : tick
    task automatic chk_val(input logic signed [PHC_W-1:0] got, input logic signed [PHC_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t value %0d expected %0d", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    // pins pass a synchroniser, so each pulse is held two cycles
    task automatic pin(ref logic p);
        p = 1'h1;
        tick(2);
        p = 1'h0;
        tick(4);
    endtask : pin
    task automatic host_preset(input logic signed [PHC_W-1:0] v, input logic [3:0] gap);
        host_val = v;
        host_gap = gap;
        go = 1'h1;
        tick(1);
        go = 1'h0;
        for (int w = 0; w < 40 && host_done !== 1'h1; w++) tick(1);
        tick(2);
    endtask : host_preset
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            conclude();
        end
    end
    ////////////////////////////////////////
    initial begin
        tick(10);
        i_nrst = 1'h1;
        tick(2);
        chk_bit(o_measuring, 1'h1);
        chk_val(o_current | o_max | o_min | o_pp | o_value, 32'h0);
        chk_val(32'(o_judge), 32'(PHC_JUDGE_GO));
        for (int k = 0; k < 4; k++) begin
            i_limit_wr_idx = 2'(k);
            i_limit_upper = lim_u[k];
            i_limit_lower = lim_l[k];
            i_limit_wr = 1'h1;
            tick(1);
        end
        i_limit_wr = 1'h0;
        i_count = 32'h64;
        host_preset(32'h32, 4'h0);
        chk_val(o_current, 32'h32);
        pin(i_start_pin);
        chk_val(o_max, 32'h32);
        chk_val(o_min, 32'h32);
        chk_val(o_pp, 32'h0);
        emax = 32'h32;
        emin = 32'h32;
        foreach (rows[k]) begin
            i_count = rows[k].cnt;
            i_mode = rows[k].md;
            i_limit_sel = rows[k].sel;
            tick(4);
            ecur = rows[k].cnt - 32'h32;
            if (ecur > emax) emax = ecur;
            if (ecur < emin) emin = ecur;
            chk_val(o_current, ecur);
            chk_val(o_max, emax);
            chk_val(o_min, emin);
            chk_val(o_pp, emax - emin);
            chk_val(o_value, rows[k].val);
            chk_val(32'(o_judge), 32'(rows[k].jd));
        end
        i_mode = PHC_MODE_MAX;
        tick(2);
        i_pause = 1'h1;
        i_count = 32'h82;
        tick(4);
        chk_val(o_current, 32'h50);
        chk_val(o_max, 32'h3D);
        chk_val(o_value, 32'h3D);
        chk_bit(o_hold_active, 1'h1);
        i_pause = 1'h0;
        tick(4);
        chk_val(o_max, 32'h50);
        i_start_is_hold = 1'h1;
        i_mode = PHC_MODE_CUR;
        i_start_pin = 1'h1;
        tick(4);
        i_count = 32'h8C;
        tick(4);
        chk_val(o_value, 32'h50);
        i_mode = PHC_MODE_MAX;
        tick(4);
        chk_val(o_value, 32'h5A);
        i_start_pin = 1'h0;
        i_start_is_hold = 1'h0;
        tick(4);
        pin(i_reset_pin);
        chk_val(o_current | o_max | o_min | o_pp | o_value, 32'h0);
        i_ref_use = 1'h1;
        i_nrst = 1'h0;
        tick(2);
        i_nrst = 1'h1;
        tick(4);
        chk_bit(o_measuring, 1'h0);
        pin(i_ref_pin);
        chk_bit(o_measuring, 1'h1);
        host_preset(32'h12C, 4'h3);
        chk_bit(o_offset_valid, 1'h1);
        pin(i_reset_pin);
        chk_bit(o_measuring, 1'h0);
        i_count = 32'hC8;
        pin(i_ref_pin);
        chk_val(o_current, 32'h12C);
        i_offset_clear = 1'h1;
        tick(1);
        i_offset_clear = 1'h0;
        chk_bit(o_offset_valid, 1'h0);
        conclude();
    end
endmodule : test_peak_hold_comparator
bind phc_peak_hold_comparator phc_checker_sva checker_i (.*);
`default_nettype wire
